//--- hw/riv_regs.svh
// Offsets, field positions and reset values for the interrupt vectoring block.
// Assumes a 24-bit word address space; included by bare name.
`ifndef RIV_REGS_SVH
`define RIV_REGS_SVH
`define RIV_ADDR_W        24
`define RIV_BASE_ALIGN_W  8
`define RIV_RESET_VECTOR  24'h000000
`define RIV_OFS_EXT0      8'h01
`define RIV_OFS_SER_TX    8'h05
`define RIV_OFS_SER_RX    8'h06
`define RIV_OFS_TIMER0    8'h09
`define RIV_OFS_TIMER1    8'h0A
`define RIV_OFS_DMA0      8'h0B
`define RIV_OFS_DMA1      8'h0C
`define RIV_OFS_TRAP0     8'h20
`define RIV_NUM_EXT       4
`define RIV_NUM_TRAPS     32
`define RIV_BASE_RESET    16'h0000
`endif

//--- hw/riv_pkg.sv
// Types shared by the interrupt vectoring block.
// Assumes the constants header is included beside it.
package riv_pkg;
  typedef struct packed {
    logic        valid;
    logic [23:0] addr;
  } riv_vector_t;
  typedef enum logic [1:0] {
    RIV_ST_RESET = 2'b00,
    RIV_ST_RUN   = 2'b01,
    RIV_ST_IDLE  = 2'b10
  } riv_state_t;
endpackage : riv_pkg

//--- hw/riv_vectoring.sv
// Interrupt and trap vector generation with relocatable table base.
// Assumes the core pulses vector_ack when it has taken the presented vector,
// and that all inputs are synchronous to clk.
//
// Behaviour
// - Each external request selectable as edge or level sensitive.
// - Table base is a pointer aligned to 256 words.
// - After reset the reset vector is address zero, ignoring base.
// - External requests 0..3 vector to base plus 01h..04h.
// - Serial transmit at base plus 05h, receive at base plus 06h.
// - Timer 0 at base plus 09h, timer 1 at base plus 0Ah.
// - DMA 0 at base plus 0Bh, DMA 1 at base plus 0Ch.
// - Trap n vectors to base plus 20h plus n.
// - Offsets 00h, 07h, 08h, 0Dh..1Fh never produced.
// - Clock-stopped idle mode exits on any external request.
`timescale 1ns/10ps
`include "riv_regs.svh"
module riv_vectoring #(
  parameter int NUM_EXT = `RIV_NUM_EXT
) (
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  input  wire logic [15:0]              vector_table_base_pointer,
  input  wire logic [NUM_EXT-1:0]       ext_edge_mode,
  input  wire logic [NUM_EXT-1:0]       ext_enable,
  input  wire logic                     external_request_0,
  input  wire logic                     external_request_1,
  input  wire logic                     external_request_2,
  input  wire logic                     external_request_3,
  input  wire logic                     serial_transmit_event,
  input  wire logic                     serial_receive_event,
  input  wire logic                     timer0_event,
  input  wire logic                     timer1_event,
  input  wire logic                     dma0_done_event,
  input  wire logic                     dma1_done_event,
  input  wire logic                     trap_req,
  input  wire logic [4:0]               trap_num,
  input  wire logic                     enter_clock_stopped_idle_mode,
  input  wire logic                     vector_ack,
  output logic                          vector_valid,
  output logic [23:0]                   vector_addr,
  output logic                          vector_is_reset,
  output logic                          clock_stopped_idle_mode,
  output logic [NUM_EXT-1:0]            ext_pending
);

  logic [NUM_EXT-1:0] ext_in;
  logic [NUM_EXT-1:0] ext_prev_q;
  logic [NUM_EXT-1:0] ext_pend_q;
  logic [NUM_EXT-1:0] ext_req;
  logic [NUM_EXT-1:0] ext_clr;
  logic [5:0]         per_pend_q;
  logic [5:0]         per_in;
  logic [5:0]         per_clr;
  logic               trap_pend_q;
  logic [4:0]         trap_num_q;
  riv_pkg::riv_state_t state_q;
  riv_pkg::riv_vector_t vec_q;
  riv_pkg::riv_vector_t vec_d;
  logic [7:0]         ofs_d;
  logic               sel_ext;
  logic               sel_per;
  logic [1:0]         ext_idx;
  logic [2:0]         per_idx;
  logic [7:0]         per_ofs [6];
  logic               pick_ext_q;
  logic               pick_per_q;
  logic [1:0]         pick_ext_idx_q;
  logic [2:0]         pick_per_idx_q;

  assign ext_in = {external_request_3, external_request_2, external_request_1, external_request_0};
  assign per_in = {dma1_done_event, dma0_done_event, timer1_event, timer0_event,
                   serial_receive_event, serial_transmit_event};

  // Fixed offsets of the peripheral sources in priority order
  assign per_ofs[0] = `RIV_OFS_SER_TX;
  assign per_ofs[1] = `RIV_OFS_SER_RX;
  assign per_ofs[2] = `RIV_OFS_TIMER0;
  assign per_ofs[3] = `RIV_OFS_TIMER1;
  assign per_ofs[4] = `RIV_OFS_DMA0;
  assign per_ofs[5] = `RIV_OFS_DMA1;

  // Previous input level for edge detection
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_prev_q <= '0;
    end else begin
      ext_prev_q <= ext_in;
    end
  end

  // Per-input trigger handling
  genvar g;
  generate
    for (g = 0; g < NUM_EXT; g++) begin : g_ext
      // Edge latch, set wins; only armed edge lines latch, so no stale edge fires later
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          ext_pend_q[g] <= 1'b0;
        end else if (ext_in[g] && !ext_prev_q[g] && ext_edge_mode[g] && ext_enable[g]) begin
          ext_pend_q[g] <= 1'b1;
        end else if (ext_clr[g]) begin
          ext_pend_q[g] <= 1'b0;
        end
      end
      assign ext_req[g] = ext_enable[g] & (ext_edge_mode[g] ? ext_pend_q[g] : ext_in[g]);
    end
  endgenerate

  // Peripheral events latch until serviced; a new event beats the clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      per_pend_q <= '0;
    end else begin
      per_pend_q <= per_in | (per_pend_q & ~per_clr);
    end
  end

  // Software trap request held until serviced
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      trap_pend_q <= 1'b0;
      trap_num_q  <= 5'h00;
    end else if (trap_req && !trap_pend_q) begin
      trap_pend_q <= 1'b1;
      trap_num_q  <= trap_num;
    end else if (state_q == riv_pkg::RIV_ST_RUN && vec_q.valid && vector_ack && !pick_ext_q && !pick_per_q) begin
      trap_pend_q <= 1'b0;
    end
  end

  // Priority pick: external lowest index first, then peripherals, then trap
  always_comb begin
    sel_ext = 1'b0;
    sel_per = 1'b0;
    ext_idx = 2'd0;
    per_idx = 3'd0;
    for (int i = NUM_EXT - 1; i >= 0; i--) begin
      if (ext_req[i]) begin
        sel_ext = 1'b1;
        ext_idx = 2'(i);
      end
    end
    for (int i = 5; i >= 0; i--) begin
      if (per_pend_q[i]) begin
        sel_per = 1'b1;
        per_idx = 3'(i);
      end
    end
  end

  always_comb begin
    ofs_d = `RIV_OFS_TRAP0 + {3'b000, trap_num_q};
    if (sel_ext) begin
      ofs_d = `RIV_OFS_EXT0 + {6'b000000, ext_idx};
    end else if (sel_per) begin
      ofs_d = per_ofs[per_idx];
    end
  end

  // Base aligned by construction: low eight bits are the offset
  always_comb begin
    vec_d.valid = sel_ext | sel_per | trap_pend_q;
    vec_d.addr  = {vector_table_base_pointer, ofs_d};
  end

  // Clear strobes for the entry the core accepted
  always_comb begin
    ext_clr = '0;
    per_clr = '0;
    if (state_q == riv_pkg::RIV_ST_RUN && vec_q.valid && vector_ack) begin
      if (pick_ext_q) begin
        ext_clr[pick_ext_idx_q] = 1'b1;
      end else if (pick_per_q) begin
        per_clr[pick_per_idx_q] = 1'b1;
      end
    end
  end

  // Mode sequencing: reset vector first, idle until an external request
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= riv_pkg::RIV_ST_RESET;
    end else begin
      unique case (state_q)
        riv_pkg::RIV_ST_RESET: begin
          if (vector_ack) begin
            state_q <= riv_pkg::RIV_ST_RUN;
          end
        end
        riv_pkg::RIV_ST_RUN: begin
          if (enter_clock_stopped_idle_mode) begin
            state_q <= riv_pkg::RIV_ST_IDLE;
          end
        end
        riv_pkg::RIV_ST_IDLE: begin
          if (|ext_in) begin
            state_q <= riv_pkg::RIV_ST_RUN;
          end
        end
        default: begin
          state_q <= riv_pkg::RIV_ST_RESET;
        end
      endcase
    end
  end

  // Registered vector; held off while idle since the core is stopped
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vec_q.valid <= 1'b1;
      vec_q.addr  <= `RIV_RESET_VECTOR;
    end else if (state_q == riv_pkg::RIV_ST_RESET) begin
      // Reset vector fixed at zero; withdrawn on the edge the core takes it
      vec_q.valid <= !vector_ack;
      vec_q.addr  <= `RIV_RESET_VECTOR;
    end else if (state_q == riv_pkg::RIV_ST_IDLE) begin
      vec_q.valid <= 1'b0;
      vec_q.addr  <= vec_q.addr;
    end else if (vec_q.valid && vector_ack) begin
      vec_q.valid <= 1'b0;
      vec_q.addr  <= vec_q.addr;
    end else begin
      vec_q <= vec_d;
    end
  end

  // Source behind the presented vector; a newer winner must not be cleared by this ack
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pick_ext_q     <= 1'b0;
      pick_per_q     <= 1'b0;
      pick_ext_idx_q <= 2'h0;
      pick_per_idx_q <= 3'h0;
    end else if (state_q == riv_pkg::RIV_ST_RUN && !(vec_q.valid && vector_ack)) begin
      pick_ext_q     <= sel_ext;
      pick_per_q     <= sel_per;
      pick_ext_idx_q <= ext_idx;
      pick_per_idx_q <= per_idx;
    end
  end

  // Output flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vector_is_reset         <= 1'b1;
      clock_stopped_idle_mode <= 1'b0;
      ext_pending             <= '0;
    end else begin
      vector_is_reset         <= (state_q == riv_pkg::RIV_ST_RESET) && !vector_ack;
      clock_stopped_idle_mode <= (state_q == riv_pkg::RIV_ST_IDLE) ? !(|ext_in) : enter_clock_stopped_idle_mode
                                 && state_q == riv_pkg::RIV_ST_RUN;
      ext_pending             <= ext_req;
    end
  end

  assign vector_valid = vec_q.valid;
  assign vector_addr  = vec_q.addr;

endmodule : riv_vectoring

//--- sim/riv_source_model.sv
// Model of the interrupt sources: four request pins, six peripheral events.
// Assumes the bench calls its tasks from a process tied to clk.
`timescale 1ns/10ps
module riv_source_model (
  input  wire logic       clk,
  output logic      [3:0] ext_line,
  output logic      [5:0] periph_evt
);
  // Pins idle low, events are one-cycle flags
  initial begin
    ext_line = 4'h0;
    periph_evt = 6'h00;
  end
  task automatic set_line(input int i, input logic v);
    @(negedge clk);
    ext_line[i] = v;
  endtask : set_line
  // Sources 0..3 are pins, 4..9 peripherals; all one cycle wide
  task automatic fire(input int k);
    if (k < 4) begin
      set_line(k, 1'b1);
      set_line(k, 1'b0);
    end else begin
      @(negedge clk);
      periph_evt[k-4] = 1'b1;
      @(negedge clk);
      periph_evt[k-4] = 1'b0;
    end
  endtask : fire
endmodule : riv_source_model

//--- sim/riv_vectoring_monitor.sv
// Port checker for the vectoring block.
// Assumes it is bound into every instance of riv_vectoring.
`timescale 1ns/10ps
module riv_vectoring_monitor #(
  parameter int NUM_EXT = 4
) (
  input wire logic               clk,
  input wire logic               rst_b,
  input wire logic [15:0]        vector_table_base_pointer,
  input wire logic [NUM_EXT-1:0] ext_edge_mode,
  input wire logic [NUM_EXT-1:0] ext_enable,
  input wire logic               external_request_0,
  input wire logic               external_request_1,
  input wire logic               vector_ack,
  input wire logic               vector_valid,
  input wire logic [23:0]        vector_addr,
  input wire logic               vector_is_reset,
  input wire logic               clock_stopped_idle_mode,
  input wire logic [NUM_EXT-1:0] ext_pending
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Low byte of the presented vector
  wire logic [7:0] ofs = vector_addr[7:0];
  a_reset_addr: assert property (vector_is_reset |-> vector_addr == 24'h000000)
    else $error("reset vector not at zero");
  a_reset_hold: assert property (vector_is_reset && !vector_ack |=> vector_is_reset && vector_valid)
    else $error("reset vector withdrawn before ack");
  a_base_field: assert property (vector_valid && !vector_is_reset && $stable(vector_table_base_pointer)
    |-> vector_addr[23:8] == vector_table_base_pointer)
    else $error("vector outside table base");
  a_no_reserved: assert property (vector_valid && !vector_is_reset
    |-> !(ofs inside {8'h00, 8'h07, 8'h08, [8'h0D:8'h1F]}) && ofs < 8'h40)
    else $error("reserved offset presented");
  a_ack_drops: assert property (vector_valid && vector_ack |=> !vector_valid)
    else $error("vector held after ack");
  a_idle_quiet: assert property (clock_stopped_idle_mode |-> !vector_valid)
    else $error("vector presented while idle");
  a_idle_wake: assert property (clock_stopped_idle_mode && external_request_0 |=> !clock_stopped_idle_mode)
    else $error("idle not left on request");
  a_level_follow: assert property (!ext_edge_mode[0] && ext_enable[0]
    |=> ext_pending[0] == $past(external_request_0))
    else $error("level request not followed");
  a_edge_latch: assert property (ext_edge_mode[1] && ext_enable[1] && $rose(external_request_1)
    |-> ##2 ext_pending[1])
    else $error("edge request not latched");
endmodule : riv_vectoring_monitor
bind riv_vectoring riv_vectoring_monitor #(.NUM_EXT(NUM_EXT)) u_riv_vectoring_monitor (.clk(clk),
  .rst_b(rst_b), .vector_table_base_pointer(vector_table_base_pointer), .ext_edge_mode(ext_edge_mode),
  .ext_enable(ext_enable), .external_request_0(external_request_0), .external_request_1(external_request_1),
  .vector_ack(vector_ack), .vector_valid(vector_valid), .vector_addr(vector_addr),
  .vector_is_reset(vector_is_reset), .clock_stopped_idle_mode(clock_stopped_idle_mode),
  .ext_pending(ext_pending));

//--- sim/relocatable_interrupt_vectoring_tb.sv
// Self-checking bench for the vectoring block.
// Assumes design, package and source model are compiled first.
`timescale 1ns/10ps
module relocatable_interrupt_vectoring_tb;
  logic        clk = 1'b0, rst_b = 1'b0, trap_req = 1'b0, idle_req = 1'b0, ack = 1'b0;
  logic [15:0] ptr = 16'h0012;
  logic [3:0]  mode = 4'hF, en = 4'hF, ext, pend;
  logic [5:0]  evt;
  logic [4:0]  tnum = 5'h00;
  logic        valid, is_rst, idle;
  logic [23:0] addr;
  int          num_errors = 0, check_count = 0;
  localparam logic [7:0] OFS [10] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h09, 8'h0A, 8'h0B, 8'h0C};
  // 50 ns clock
  always #25 clk = ~clk;
  riv_vectoring u_riv_vectoring (.clk(clk), .rst_b(rst_b), .vector_table_base_pointer(ptr),
    .ext_edge_mode(mode), .ext_enable(en), .external_request_0(ext[0]), .external_request_1(ext[1]),
    .external_request_2(ext[2]), .external_request_3(ext[3]), .serial_transmit_event(evt[0]),
    .serial_receive_event(evt[1]), .timer0_event(evt[2]), .timer1_event(evt[3]), .dma0_done_event(evt[4]),
    .dma1_done_event(evt[5]), .trap_req(trap_req), .trap_num(tnum), .enter_clock_stopped_idle_mode(idle_req),
    .vector_ack(ack), .vector_valid(valid), .vector_addr(addr), .vector_is_reset(is_rst),
    .clock_stopped_idle_mode(idle), .ext_pending(pend));
  riv_source_model u_riv_source_model (.clk(clk), .ext_line(ext), .periph_evt(evt));
  task automatic chk(input logic [24:0] seen, input logic [24:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  // Bounded wait for a vector, compare, then one-cycle ack
  task automatic take(input logic [23:0] exp);
    int n;
    n = 0;
    while (valid !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk({valid, addr}, {1'b1, exp});
    ack = 1'b1;
    @(negedge clk);
    ack = 1'b0;
    @(negedge clk);
  endtask : take
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict
  // Reset held two cycles, then the fixed reset vector must be taken first
  task automatic test_reset();
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    chk(is_rst, 1'b1);
    take(24'h000000);
    chk(is_rst, 1'b0);
    $display("reset vector done");
  endtask : test_reset
  // Every source alone, one at a time, against its table slot
  task automatic test_sources();
    for (int k = 0; k < 10; k++) begin
      u_riv_source_model.fire(k);
      take({ptr, OFS[k]});
    end
    $display("source table done");
  endtask : test_sources
  // First and last trap, with the base moved to the top of the space
  task automatic test_traps();
    ptr = 16'hFFFF;
    for (int i = 0; i < 2; i++) begin
      tnum = 5'(i * 31);
      trap_req = 1'b1;
      @(negedge clk);
      trap_req = 1'b0;
      take({ptr, 8'h20 + 8'(i * 31)});
    end
    $display("traps done");
  endtask : test_traps
  // Level request repeats while high and vanishes when the pin falls; disabled pin is ignored
  task automatic test_level();
    mode = 4'h0;
    u_riv_source_model.set_line(2, 1'b1);
    take({ptr, 8'h03});
    take({ptr, 8'h03});
    chk(pend, 4'h4);
    u_riv_source_model.set_line(2, 1'b0);
    repeat (2) @(negedge clk);
    chk(valid, 1'b0);
    en = 4'hD;
    u_riv_source_model.set_line(1, 1'b1);
    repeat (4) @(negedge clk);
    chk(valid, 1'b0);
    chk(pend, 4'h0);
    u_riv_source_model.set_line(1, 1'b0);
    en = 4'hF;
    mode = 4'hF;
    $display("level and enable done");
  endtask : test_level
  // Idle entered on request, left on an external pin, then that pin is vectored
  task automatic test_idle();
    idle_req = 1'b1;
    @(negedge clk);
    idle_req = 1'b0;
    @(negedge clk);
    chk(idle, 1'b1);
    u_riv_source_model.set_line(0, 1'b1);
    @(negedge clk);
    chk(idle, 1'b0);
    u_riv_source_model.set_line(0, 1'b0);
    take({ptr, 8'h01});
    $display("idle wake done");
  endtask : test_idle
  // Main sequence
  initial begin
    test_reset();
    test_sources();
    test_traps();
    test_level();
    test_idle();
    give_verdict();
  end
  // Watchdog well past the expected run length
  initial begin
    #(50 * 2000);
    num_errors++;
    give_verdict();
  end
endmodule : relocatable_interrupt_vectoring_tb
